/* msp_defines.svh */
`ifndef MSP_DEFINES_SVH
`define MSP_DEFINES_SVH

`define MSP_CLK_HZ         125000000
`define MSP_MAX_BAUD       921000
`define MSP_CLKS_PER_BIT   ((`MSP_CLK_HZ + `MSP_MAX_BAUD - 1) / `MSP_MAX_BAUD)
`define MSP_DATA_BITS      8
`define MSP_MAIN_RXD_RST   1'h1
`define MSP_AUX_RXD_RST    1'h0
`define MSP_AUX_CTS_N_RST  1'h0
`define MSP_SYNC_RST       1'h1

`endif

/* msp_pkg.sv */
package msp_pkg;
  typedef enum logic [1:0] {MSP_W8, MSP_W5, MSP_W4, MSP_W2} msp_wires_t;
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} msp_state_t;
endpackage : msp_pkg

/* msp_link_if.sv */
`timescale 1ns/1ps
interface msp_link_if;
  logic main_host_tx_data;
  logic aux_host_tx_data;
  logic main_request_to_send_n;
  logic aux_request_to_send_n;
  logic main_terminal_ready_n;
  logic main_host_rx_data_o, main_host_rx_data_oe;
  logic aux_host_rx_data_o, aux_host_rx_data_oe;
  logic main_clear_to_send_n_o, main_clear_to_send_n_oe;
  logic aux_clear_to_send_n_o, aux_clear_to_send_n_oe;
  logic main_set_ready_n_o, main_set_ready_n_oe;
  logic main_carrier_detect_n_o, main_carrier_detect_n_oe;
  logic main_ring_indicator_n_o, main_ring_indicator_n_oe;
  // undriven lines float high through pull-ups
  logic main_host_rx_data, aux_host_rx_data, main_clear_to_send_n, aux_clear_to_send_n;
  logic main_set_ready_n, main_carrier_detect_n, main_ring_indicator_n;
  assign main_host_rx_data     = main_host_rx_data_oe ? main_host_rx_data_o : 1'h1;
  assign aux_host_rx_data      = aux_host_rx_data_oe ? aux_host_rx_data_o : 1'h1;
  assign main_clear_to_send_n  = main_clear_to_send_n_oe ? main_clear_to_send_n_o : 1'h1;
  assign aux_clear_to_send_n   = aux_clear_to_send_n_oe ? aux_clear_to_send_n_o : 1'h1;
  assign main_set_ready_n      = main_set_ready_n_oe ? main_set_ready_n_o : 1'h1;
  assign main_carrier_detect_n = main_carrier_detect_n_oe ? main_carrier_detect_n_o : 1'h1;
  assign main_ring_indicator_n = main_ring_indicator_n_oe ? main_ring_indicator_n_o : 1'h1;

  modport device (
    input  main_host_tx_data, aux_host_tx_data, main_request_to_send_n, aux_request_to_send_n,
    input  main_terminal_ready_n,
    output main_host_rx_data_o, main_host_rx_data_oe, aux_host_rx_data_o, aux_host_rx_data_oe,
    output main_clear_to_send_n_o, main_clear_to_send_n_oe, aux_clear_to_send_n_o, aux_clear_to_send_n_oe,
    output main_set_ready_n_o, main_set_ready_n_oe, main_carrier_detect_n_o, main_carrier_detect_n_oe,
    output main_ring_indicator_n_o, main_ring_indicator_n_oe
  );
  modport host (
    output main_host_tx_data, aux_host_tx_data, main_request_to_send_n, aux_request_to_send_n,
    output main_terminal_ready_n,
    input  main_host_rx_data, aux_host_rx_data, main_clear_to_send_n, aux_clear_to_send_n,
    input  main_set_ready_n, main_carrier_detect_n, main_ring_indicator_n
  );
endinterface : msp_link_if

/* msp_device.sv */
`timescale 1ns/1ps
`include "msp_defines.svh"
module msp_device #(
  parameter int CPB = `MSP_CLKS_PER_BIT
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   nrst_i,
  msp_link_if.device                  link,
  input  wire msp_pkg::msp_wires_t    main_wires_i,
  input  wire logic                   gpio_claim_i,
  input  wire logic [1:0]             flow_en_i,
  input  wire logic [1:0][7:0]        tx_data_i,
  input  wire logic [1:0]             tx_valid_i,
  output logic      [1:0]             tx_ready_o,
  output logic      [1:0][7:0]        rx_data_o,
  output logic      [1:0]             rx_valid_o,
  input  wire logic [1:0]             rx_ready_i,
  input  wire logic                   set_ready_i,
  input  wire logic                   carrier_i,
  input  wire logic                   ring_i,
  output logic                        terminal_ready_o,
  output logic                        main_active_o
);
  import msp_pkg::*;
  localparam int CW = $clog2(CPB + 1);
  localparam logic [CW-1:0] FULL = CW'(CPB - 1);
  localparam logic [CW-1:0] HALF = CW'(CPB / 2);

  function automatic logic line_used(msp_wires_t w, logic ext);
    // ext: line exists only in eight-wire (otherwise in every mode but two-wire)
    line_used = ext ? (w == MSP_W8) : (w != MSP_W2);
  endfunction : line_used

  // three-stage input sync, value moves once stages two and three agree
  logic [4:0] raw, s1_q, s2_q, s3_q, f_q, f_d;
  assign raw = {link.main_terminal_ready_n, link.aux_request_to_send_n,
                link.main_request_to_send_n, link.aux_host_tx_data, link.main_host_tx_data};
  assign f_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & f_q);
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= {5{`MSP_SYNC_RST}};
      s2_q <= {5{`MSP_SYNC_RST}};
      s3_q <= {5{`MSP_SYNC_RST}};
      f_q  <= {5{`MSP_SYNC_RST}};
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q  <= f_d;
    end
  end

  wire main_act  = !gpio_claim_i;
  wire dtr_seen  = line_used(main_wires_i, 1'h0) && (main_wires_i != MSP_W4) && !f_q[4];
  wire ext_oe    = main_act && line_used(main_wires_i, 1'h1);
  assign main_active_o    = main_act;
  assign terminal_ready_o = dtr_seen;

  // status lines, main port only
  logic dsr_q, dsr_oe_q, dcd_q, dcd_oe_q, ri_q, ri_oe_q;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dsr_q    <= 1'h1;
      dsr_oe_q <= 1'h0;
      dcd_q    <= 1'h1;
      dcd_oe_q <= 1'h0;
      ri_q     <= 1'h1;
      ri_oe_q  <= 1'h0;
    end else begin
      dsr_q    <= !set_ready_i;
      dsr_oe_q <= ext_oe;
      dcd_q    <= !carrier_i;
      dcd_oe_q <= ext_oe;
      ri_q     <= !ring_i;
      ri_oe_q  <= ext_oe;
    end
  end
  assign link.main_set_ready_n_o      = dsr_q;
  assign link.main_set_ready_n_oe     = dsr_oe_q;
  assign link.main_carrier_detect_n_o  = dcd_q;
  assign link.main_carrier_detect_n_oe = dcd_oe_q;
  assign link.main_ring_indicator_n_o  = ri_q;
  assign link.main_ring_indicator_n_oe = ri_oe_q;

  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam logic RXD_RST = (p == 0) ? `MSP_MAIN_RXD_RST : `MSP_AUX_RXD_RST;
    localparam logic CTS_RST = (p == 0) ? 1'h1 : `MSP_AUX_CTS_N_RST;
    localparam logic CTS_OE  = (p == 0) ? 1'h0 : 1'h1;
    wire act   = (p == 0) ? main_act : 1'h1;
    wire flow  = flow_en_i[p] && ((p == 1) || (main_wires_i != MSP_W2));
    wire rxin  = f_q[p];
    wire rts_n = f_q[2 + p];

    // one owner per line, so each port keeps its own output flops
    logic hrx_q, hrx_oe_q, cts_q, cts_oe_q;
    if (p == 0) begin : g_main
      assign link.main_host_rx_data_o     = hrx_q;
      assign link.main_host_rx_data_oe    = hrx_oe_q;
      assign link.main_clear_to_send_n_o  = cts_q;
      assign link.main_clear_to_send_n_oe = cts_oe_q;
    end else begin : g_aux
      assign link.aux_host_rx_data_o      = hrx_q;
      assign link.aux_host_rx_data_oe     = hrx_oe_q;
      assign link.aux_clear_to_send_n_o   = cts_q;
      assign link.aux_clear_to_send_n_oe  = cts_oe_q;
    end

    // receiver
    msp_state_t rst_q, rst_d;
    logic [CW-1:0] rcnt_q, rcnt_d;
    logic [2:0] ridx_q, ridx_d;
    logic [7:0] rsh_q, rsh_d;
    logic push;
    always_comb begin
      rst_d  = rst_q;
      rcnt_d = rcnt_q;
      ridx_d = ridx_q;
      rsh_d  = rsh_q;
      push   = 1'h0;
      case (rst_q)
        ST_IDLE: if (!rxin && act) begin
          rst_d  = ST_START;
          rcnt_d = HALF;
        end
        ST_START: if (rcnt_q != '0) begin
          rcnt_d = rcnt_q - 1'h1;
        end else if (rxin) begin
          rst_d = ST_IDLE;
        end else begin
          rst_d  = ST_DATA;
          rcnt_d = FULL;
          ridx_d = 3'h0;
        end
        ST_DATA: if (rcnt_q != '0) begin
          rcnt_d = rcnt_q - 1'h1;
        end else begin
          rsh_d  = {rxin, rsh_q[7:1]};
          ridx_d = ridx_q + 3'h1;
          rcnt_d = FULL;
          if (ridx_q == 3'(`MSP_DATA_BITS - 1)) rst_d = ST_STOP;
        end
        default: if (rcnt_q != '0) begin
          rcnt_d = rcnt_q - 1'h1;
        end else begin
          push  = rxin;
          rst_d = ST_IDLE;
        end
      endcase
    end

    // two-entry receive buffer
    logic [7:0] mem_q [2];
    logic wp_q, rp_q;
    logic [1:0] cnt_q;
    wire full = (cnt_q == 2'h2);
    wire wr   = push && !full;
    wire rd   = (cnt_q != 2'h0) && rx_ready_i[p];
    assign rx_valid_o[p] = (cnt_q != 2'h0);
    assign rx_data_o[p]  = mem_q[rp_q];

    // transmitter
    msp_state_t tst_q, tst_d;
    logic [CW-1:0] tcnt_q, tcnt_d;
    logic [3:0] tbit_q, tbit_d;
    logic [9:0] tsh_q, tsh_d;
    assign tx_ready_o[p] = (tst_q == ST_IDLE) && act && (!flow || !rts_n);
    always_comb begin
      tst_d  = tst_q;
      tcnt_d = tcnt_q;
      tbit_d = tbit_q;
      tsh_d  = tsh_q;
      case (tst_q)
        ST_IDLE: if (tx_valid_i[p] && tx_ready_o[p]) begin
          tst_d  = ST_DATA;
          tsh_d  = {1'h1, tx_data_i[p], 1'h0};
          tcnt_d = FULL;
          tbit_d = 4'h0;
        end
        default: if (tcnt_q != '0) begin
          tcnt_d = tcnt_q - 1'h1;
        end else if (tbit_q == 4'h9) begin
          tst_d = ST_IDLE;
        end else begin
          tsh_d  = {1'h1, tsh_q[9:1]};
          tbit_d = tbit_q + 4'h1;
          tcnt_d = FULL;
        end
      endcase
    end
    wire line_d = (tst_q == ST_IDLE) ? 1'h1 : tsh_q[0];
    // leave one slot for a character already in flight
    wire cts_d  = flow && (cnt_q != 2'h0);

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
        rst_q  <= ST_IDLE;
        rcnt_q <= '0;
        ridx_q <= 3'h0;
        rsh_q  <= 8'h00;
        tst_q  <= ST_IDLE;
        tcnt_q <= '0;
        tbit_q <= 4'h0;
        tsh_q  <= 10'h3ff;
        wp_q   <= 1'h0;
        rp_q   <= 1'h0;
        cnt_q  <= 2'h0;
        mem_q  <= '{default: 8'h00};
        hrx_q    <= RXD_RST;
        hrx_oe_q <= 1'h1;
        cts_q    <= CTS_RST;
        cts_oe_q <= CTS_OE;
      end else begin
        rst_q  <= rst_d;
        rcnt_q <= rcnt_d;
        ridx_q <= ridx_d;
        rsh_q  <= rsh_d;
        tst_q  <= tst_d;
        tcnt_q <= tcnt_d;
        tbit_q <= tbit_d;
        tsh_q  <= tsh_d;
        if (wr) mem_q[wp_q] <= rsh_q;
        wp_q  <= wp_q ^ wr;
        rp_q  <= rp_q ^ rd;
        cnt_q <= cnt_q + {1'h0, wr} - {1'h0, rd};
        hrx_q    <= line_d;
        hrx_oe_q <= act;
        cts_q    <= cts_d;
        cts_oe_q <= act && ((p == 1) || line_used(main_wires_i, 1'h0));
      end
    end
  end
endmodule : msp_device

/* msp_host.sv */
`timescale 1ns/1ps
`include "msp_defines.svh"
module msp_host #(
  parameter int CPB = `MSP_CLKS_PER_BIT
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   nrst_i,
  msp_link_if.host                    link,
  input  wire msp_pkg::msp_wires_t    main_wires_i,
  input  wire logic [1:0]             flow_en_i,
  input  wire logic                   dtr_assert_i,
  input  wire logic [1:0][7:0]        tx_data_i,
  input  wire logic [1:0]             tx_valid_i,
  output logic      [1:0]             tx_ready_o,
  output logic      [1:0][7:0]        rx_data_o,
  output logic      [1:0]             rx_valid_o,
  input  wire logic [1:0]             rx_ready_i,
  output logic                        set_ready_o,
  output logic                        carrier_o,
  output logic                        ring_o
);
  import msp_pkg::*;
  localparam int CW = $clog2(CPB + 1);
  localparam logic [CW-1:0] FULL = CW'(CPB - 1);
  localparam logic [CW-1:0] HALF = CW'(CPB / 2);

  logic [6:0] raw, s1_q, s2_q, s3_q, f_q, f_d;
  assign raw = {link.main_ring_indicator_n, link.main_carrier_detect_n, link.main_set_ready_n,
                link.aux_clear_to_send_n, link.main_clear_to_send_n,
                link.aux_host_rx_data, link.main_host_rx_data};
  assign f_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & f_q);
  assign set_ready_o = !f_q[4];
  assign carrier_o   = !f_q[5];
  assign ring_o      = !f_q[6];

  logic dtr_q;
  assign link.main_terminal_ready_n  = dtr_q;
  // unwired terminal-ready tied low in four- and two-wire use
  wire dtr_d = ((main_wires_i == MSP_W8) || (main_wires_i == MSP_W5)) ? !dtr_assert_i : 1'h0;

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q  <= {7{`MSP_SYNC_RST}};
      s2_q  <= {7{`MSP_SYNC_RST}};
      s3_q  <= {7{`MSP_SYNC_RST}};
      f_q   <= {7{`MSP_SYNC_RST}};
      dtr_q <= 1'h1;
    end else begin
      s1_q  <= raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      f_q   <= f_d;
      dtr_q <= dtr_d;
    end
  end

  for (genvar p = 0; p < 2; p++) begin : g_port
    wire two  = (p == 0) && (main_wires_i == MSP_W2);
    wire flow = flow_en_i[p] && !two;
    wire rxin = f_q[p];

    logic htx_q, rts_q;
    if (p == 0) begin : g_main
      assign link.main_host_tx_data      = htx_q;
      assign link.main_request_to_send_n = rts_q;
    end else begin : g_aux
      assign link.aux_host_tx_data       = htx_q;
      assign link.aux_request_to_send_n  = rts_q;
    end

    msp_state_t rst_q, rst_d;
    logic [CW-1:0] rcnt_q, rcnt_d;
    logic [2:0] ridx_q, ridx_d;
    logic [7:0] rsh_q, rsh_d;
    logic push;
    always_comb begin
      rst_d  = rst_q;
      rcnt_d = rcnt_q;
      ridx_d = ridx_q;
      rsh_d  = rsh_q;
      push   = 1'h0;
      case (rst_q)
        ST_IDLE: if (!rxin) begin
          rst_d  = ST_START;
          rcnt_d = HALF;
        end
        ST_START: if (rcnt_q != '0) begin
          rcnt_d = rcnt_q - 1'h1;
        end else if (rxin) begin
          rst_d = ST_IDLE;
        end else begin
          rst_d  = ST_DATA;
          rcnt_d = FULL;
          ridx_d = 3'h0;
        end
        ST_DATA: if (rcnt_q != '0) begin
          rcnt_d = rcnt_q - 1'h1;
        end else begin
          rsh_d  = {rxin, rsh_q[7:1]};
          ridx_d = ridx_q + 3'h1;
          rcnt_d = FULL;
          if (ridx_q == 3'(`MSP_DATA_BITS - 1)) rst_d = ST_STOP;
        end
        default: if (rcnt_q != '0) begin
          rcnt_d = rcnt_q - 1'h1;
        end else begin
          push  = rxin;
          rst_d = ST_IDLE;
        end
      endcase
    end
    // two-entry receive buffer
    logic [7:0] mem_q [2];
    logic wp_q, rp_q;
    logic [1:0] cnt_q;
    wire wr = push && (cnt_q != 2'h2);
    wire rd = (cnt_q != 2'h0) && rx_ready_i[p];
    assign rx_valid_o[p] = (cnt_q != 2'h0);
    assign rx_data_o[p]  = mem_q[rp_q];

    msp_state_t tst_q, tst_d;
    logic [CW-1:0] tcnt_q, tcnt_d;
    logic [3:0] tbit_q, tbit_d;
    logic [9:0] tsh_q, tsh_d;
    assign tx_ready_o[p] = (tst_q == ST_IDLE) && (!flow || !f_q[2 + p]);
    always_comb begin
      tst_d  = tst_q;
      tcnt_d = tcnt_q;
      tbit_d = tbit_q;
      tsh_d  = tsh_q;
      case (tst_q)
        ST_IDLE: if (tx_valid_i[p] && tx_ready_o[p]) begin
          tst_d  = ST_DATA;
          tsh_d  = {1'h1, tx_data_i[p], 1'h0};
          tcnt_d = FULL;
          tbit_d = 4'h0;
        end
        default: if (tcnt_q != '0) begin
          tcnt_d = tcnt_q - 1'h1;
        end else if (tbit_q == 4'h9) begin
          tst_d = ST_IDLE;
        end else begin
          tsh_d  = {1'h1, tsh_q[9:1]};
          tbit_d = tbit_q + 4'h1;
          tcnt_d = FULL;
        end
      endcase
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
        rst_q  <= ST_IDLE;
        rcnt_q <= '0;
        ridx_q <= 3'h0;
        rsh_q  <= 8'h00;
        wp_q   <= 1'h0;
        rp_q   <= 1'h0;
        cnt_q  <= 2'h0;
        mem_q  <= '{default: 8'h00};
        tst_q  <= ST_IDLE;
        tcnt_q <= '0;
        tbit_q <= 4'h0;
        tsh_q  <= 10'h3ff;
        htx_q  <= 1'h1;
        rts_q  <= 1'h1;
      end else begin
        rst_q  <= rst_d;
        rcnt_q <= rcnt_d;
        ridx_q <= ridx_d;
        rsh_q  <= rsh_d;
        tst_q  <= tst_d;
        tcnt_q <= tcnt_d;
        tbit_q <= tbit_d;
        tsh_q  <= tsh_d;
        if (wr) mem_q[wp_q] <= rsh_q;
        wp_q  <= wp_q ^ wr;
        rp_q  <= rp_q ^ rd;
        cnt_q <= cnt_q + {1'h0, wr} - {1'h0, rd};
        htx_q <= (tst_q == ST_IDLE) ? 1'h1 : tsh_q[0];
        // hold off the far end while a byte waits, keeping a slot for one in flight
        rts_q <= flow && (cnt_q != 2'h0);
      end
    end
  end
endmodule : msp_host

/* msp_link_asserts.sv */
`timescale 1ns/1ps
module msp_link_asserts (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic main_host_rx_data_o,
  input wire logic main_host_rx_data_oe,
  input wire logic main_host_rx_data,
  input wire logic aux_host_rx_data_o,
  input wire logic aux_host_rx_data_oe,
  input wire logic aux_clear_to_send_n_o,
  input wire logic aux_clear_to_send_n_oe,
  input wire logic main_clear_to_send_n_oe,
  input wire logic main_set_ready_n_oe,
  input wire logic main_carrier_detect_n_oe,
  input wire logic main_ring_indicator_n_oe,
  input wire logic aux_host_tx_data
);
  logic [2:0] rst_bad_q;

  // reset-time levels, judged at the first edge after release
  always_ff @(posedge clk_sys_i) begin
    rst_bad_q <= {3{!nrst_i}} & {main_clear_to_send_n_oe | main_set_ready_n_oe,
                                 !(aux_host_rx_data_oe & aux_clear_to_send_n_oe)
                                 | aux_host_rx_data_o | aux_clear_to_send_n_o,
                                 !(main_host_rx_data_oe & main_host_rx_data_o)};
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  chk_main_rxd_reset:
    assert property (!rst_bad_q[0]) else $error("main rx data not high in reset");
  chk_aux_reset_low:
    assert property (!rst_bad_q[1]) else $error("aux outputs not low in reset");
  chk_main_float_reset:
    assert property (!rst_bad_q[2]) else $error("main cts or dsr driven in reset");
  chk_start_width:
    assert property ($fell(main_host_rx_data) |=> !main_host_rx_data [*7]) else $error("main rx bit too short");
  chk_host_bit_width:
    assert property ($changed(aux_host_tx_data) |=> $stable(aux_host_tx_data) [*7])
      else $error("aux tx bit too short");
  chk_subset_order:
    assert property (main_set_ready_n_oe |-> main_clear_to_send_n_oe && main_host_rx_data_oe)
      else $error("set ready driven outside subset");
  chk_status_group:
    assert property (main_ring_indicator_n_oe == main_carrier_detect_n_oe
                     && main_carrier_detect_n_oe == main_set_ready_n_oe) else $error("status lines split");
  chk_aux_cts_driven:
    assert property (aux_clear_to_send_n_oe && aux_host_rx_data_oe) else $error("aux port not driven");
endmodule : msp_link_asserts

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
  import msp_pkg::*;
  localparam int CPB = 16;
  logic            clk_sys_i, nrst_i, gpio, dtr, set_rdy, car, ring, term_rdy, active, h_sr, h_cd, h_ri;
  msp_wires_t      wires;
  logic [1:0]      flow, d_tv, d_trdy, d_rv, d_rrdy, h_tv, h_trdy, h_rv, h_rrdy;
  logic [1:0][7:0] d_td, d_rd, h_td, h_rd;
  logic [1:0][1:0] line;
  logic [7:0]      b;
  int              fails, checked;

  msp_link_if link ();
  msp_device #(.CPB(CPB)) msp_device_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .link(link),
    .main_wires_i(wires), .gpio_claim_i(gpio), .flow_en_i(flow), .tx_data_i(d_td), .tx_valid_i(d_tv),
    .tx_ready_o(d_trdy), .rx_data_o(d_rd), .rx_valid_o(d_rv), .rx_ready_i(d_rrdy), .set_ready_i(set_rdy),
    .carrier_i(car), .ring_i(ring), .terminal_ready_o(term_rdy), .main_active_o(active));
  msp_host #(.CPB(CPB)) msp_host_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .link(link),
    .main_wires_i(wires), .flow_en_i(flow), .dtr_assert_i(dtr), .tx_data_i(h_td), .tx_valid_i(h_tv),
    .tx_ready_o(h_trdy), .rx_data_o(h_rd), .rx_valid_o(h_rv), .rx_ready_i(h_rrdy),
    .set_ready_o(h_sr), .carrier_o(h_cd), .ring_o(h_ri));
  msp_link_asserts msp_link_asserts_i (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .main_host_rx_data_o(link.main_host_rx_data_o), .main_host_rx_data_oe(link.main_host_rx_data_oe),
    .main_host_rx_data(link.main_host_rx_data), .aux_host_rx_data_o(link.aux_host_rx_data_o),
    .aux_host_rx_data_oe(link.aux_host_rx_data_oe), .aux_clear_to_send_n_o(link.aux_clear_to_send_n_o),
    .aux_clear_to_send_n_oe(link.aux_clear_to_send_n_oe),
    .main_clear_to_send_n_oe(link.main_clear_to_send_n_oe), .main_set_ready_n_oe(link.main_set_ready_n_oe),
    .main_carrier_detect_n_oe(link.main_carrier_detect_n_oe),
    .main_ring_indicator_n_oe(link.main_ring_indicator_n_oe), .aux_host_tx_data(link.aux_host_tx_data));

  // index 0 = device sending, 1 = host sending
  assign line[0] = {link.aux_host_rx_data, link.main_host_rx_data};
  assign line[1] = {link.aux_host_tx_data, link.main_host_tx_data};

  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  task automatic conclude;
    $display("counts checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  task automatic chk1(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected=%b seen=%b", name, exp, got);
    end
  endtask : chk1

  task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected=%h seen=%h", name, exp, got);
    end
  endtask : chk8

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick

  task automatic lapse(input int n);
    if (n >= 3000) begin
      fails++;
      $display("unexpected wait expected=done seen=timeout");
      conclude();
    end
  endtask : lapse

  function automatic logic [9:0] frame(input logic [7:0] v);
    return {1'b1, v, 1'b0};
  endfunction : frame

  // hand a byte over, then sample the wire mid-bit
  task automatic send(input bit who, input int p, input logic [7:0] v);
    logic [9:0] f;
    int         n;
    f = frame(v);
    n = 0;
    if (who) {h_td[p], h_tv[p]} = {v, 1'b1};
    else {d_td[p], d_tv[p]} = {v, 1'b1};
    while ((who ? h_trdy[p] : d_trdy[p]) !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    lapse(n);
    tick(1);
    if (who) h_tv[p] = 1'b0;
    else d_tv[p] = 1'b0;
    while (line[who][p] !== 1'b0 && n < 3000) begin
      tick(1);
      n++;
    end
    lapse(n);
    tick(CPB / 2);
    for (int i = 0; i < 10; i++) begin
      chk1("wire bit", f[i], line[who][p]);
      tick(CPB);
    end
  endtask : send

  task automatic recv(input bit who, input int p, input logic [7:0] v);
    int n;
    n = 0;
    while ((who ? h_rv[p] : d_rv[p]) !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    lapse(n);
    chk8("rx data", v, who ? h_rd[p] : d_rd[p]);
    if (who) h_rrdy[p] = 1'b1;
    else d_rrdy[p] = 1'b1;
    tick(1);
    {h_rrdy[p], d_rrdy[p]} = 2'b00;
    // let an edge pass before a following pop raises ready again
    tick(1);
  endtask : recv

  initial begin
    void'($urandom(32'hb6c3_3d3d));
    {fails, checked} = 0;
    {nrst_i, gpio, dtr, set_rdy, car, ring} = 6'h01;
    wires = MSP_W8;
    {flow, d_tv, d_rrdy, h_tv, h_rrdy} = 10'h300;
    {d_td, h_td} = 32'h0000_0000;
    tick(5);
    chk1("main rx data", 1'b1, link.main_host_rx_data);
    chk1("aux rx data", 1'b0, link.aux_host_rx_data);
    chk1("aux cts_n", 1'b0, link.aux_clear_to_send_n);
    chk1("main cts oe", 1'b0, link.main_clear_to_send_n_oe);
    chk1("main dsr oe", 1'b0, link.main_set_ready_n_oe);
    nrst_i = 1'b1;
    tick(2);
    for (int k = 0; k < 8; k++) begin
      b = 8'($urandom);
      send(0, k % 2, b);
      recv(1, k % 2, b);
      b = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
      send(1, k % 2, b);
      recv(0, k % 2, b);
    end
    $display("test traffic done");
    b = 8'($urandom);
    send(0, 1, b);
    tick(20);
    {d_td[1], d_tv[1]} = {~b, 1'b1};
    tick(4 * CPB);
    chk1("aux rts_n", 1'b1, link.aux_request_to_send_n);
    chk1("dev aux ready", 1'b0, d_trdy[1]);
    recv(1, 1, b);
    send(0, 1, ~b);
    recv(1, 1, ~b);
    send(1, 0, b);
    tick(20);
    {h_td[0], h_tv[0]} = {~b, 1'b1};
    tick(4 * CPB);
    chk1("main cts_n", 1'b1, link.main_clear_to_send_n);
    chk1("host main ready", 1'b0, h_trdy[0]);
    recv(0, 0, b);
    send(1, 0, ~b);
    recv(0, 0, ~b);
    $display("test flow stall done");
    flow = 2'b00;
    for (int k = 0; k < 3; k++) send(1, 1, b + 8'(k));
    tick(20);
    recv(0, 1, b);
    recv(0, 1, b + 8'h01);
    chk1("dev aux valid", 1'b0, d_rv[1]);
    flow = 2'b11;
    $display("test buffer full done");
    for (int w = 0; w < 4; w++) begin
      wires = msp_wires_t'(w);
      {dtr, set_rdy, car, ring} = 4'($urandom);
      tick(12);
      chk1("dsr oe", w == 0, link.main_set_ready_n_oe);
      chk1("cts oe", w != 3, link.main_clear_to_send_n_oe);
      chk1("host set ready", (w == 0) & set_rdy, h_sr);
      chk1("host carrier", (w == 0) & car, h_cd);
      chk1("host ring", (w == 0) & ring, h_ri);
      chk1("terminal ready", (w < 2) & dtr, term_rdy);
      chk1("dtr_n", (w >= 2) ? 1'b0 : !dtr, link.main_terminal_ready_n);
      chk1("main rts_n", 1'b0, link.main_request_to_send_n);
      if (w == 3) begin
        b = 8'($urandom);
        send(1, 0, b);
        recv(0, 0, b);
        send(0, 0, ~b);
        recv(1, 0, ~b);
      end
    end
    $display("test wire configs done");
    wires = MSP_W8;
    gpio = 1'b1;
    tick(3);
    chk1("main active", 1'b0, active);
    chk1("main rx oe", 1'b0, link.main_host_rx_data_oe);
    chk1("dev main ready", 1'b0, d_trdy[0]);
    gpio = 1'b0;
    tick(3);
    send(0, 0, b);
    recv(1, 0, b);
    nrst_i = 1'b0;
    tick(2);
    chk1("main rx data", 1'b1, link.main_host_rx_data);
    chk1("aux cts_n", 1'b0, link.aux_clear_to_send_n);
    nrst_i = 1'b1;
    tick(4);
    $display("test claim and reset done");
    conclude();
  end
endmodule : testbench
